/* dv/brfwm_top_tb.sv */
/*
 * Self-checking bench: registers, queue flags and wrap, rewind, RAM write modes, output clears.
 * Assumes the user logic model and the register map header are compiled alongside.
 */
`include "brfwm_regs.svh"
module brfwm_top_tb;
	timeunit 1ns;
	timeprecision 100ps;

	// ----------------------------------------
	// Signals
	// ----------------------------------------
	logic        sys_clk   = 1'b0;
	logic        rst_n     = 1'b0;
	logic [7:0]  reg_addr  = 8'h00;
	logic [31:0] reg_wdata = 32'h00000000;
	logic        reg_wr    = 1'b0;
	logic        reg_rd    = 1'b0;
	logic        q_rst     = 1'b0;
	logic        rewind    = 1'b0;
	logic        clr_a     = 1'b0;
	logic        clr_b     = 1'b0;
	logic        clr_all_n = 1'b1;
	logic [31:0] reg_rdata;
	logic        irq, wclk, wce, wen, rclk, read_clock_enable, ren, b_we;
	logic [7:0]  wdata, a_data, b_din, b_data;
	logic [3:0]  a_addr, b_addr;
	logic        full, afull, aempty, empty;
	int          num_errors = 0;
	int          n_checks   = 0;

	always #5 sys_clk = ~sys_clk;

	brfwm_top #(.W(8), .AW(4)) u_dut (
		.sys_clk_in(sys_clk), .rst_n_in(rst_n), .reg_addr_in(reg_addr), .reg_wdata_in(reg_wdata),
		.reg_wr_in(reg_wr), .reg_rd_in(reg_rd), .reg_rdata_out(reg_rdata), .irq_out(irq),
		.write_clock_in(wclk), .write_clock_enable_in(wce), .wr_en_in(wen), .wr_data_in(wdata),
		.a_addr_in(a_addr), .a_data_out(a_data), .read_clock_in(rclk), .read_clock_enable_in(read_clock_enable),
		.rd_en_in(ren), .b_wr_en_in(b_we), .b_data_in(b_din), .b_addr_in(b_addr), .b_data_out(b_data),
		.queue_reset_in(q_rst), .read_pointer_rewind_in(rewind), .port_a_output_clear_in(clr_a),
		.port_b_output_clear_in(clr_b), .device_wide_clear_n_in(clr_all_n), .full_flag_out(full),
		.almost_full_flag_out(afull), .almost_empty_flag_out(aempty), .empty_flag_out(empty));

	brfwm_user_model u_user (
		.sys_clk_in(sys_clk), .write_clock_out(wclk), .write_clock_enable_out(wce), .wr_en_out(wen),
		.wr_data_out(wdata), .a_addr_out(a_addr), .read_clock_out(rclk), .read_clock_enable_out(read_clock_enable),
		.rd_en_out(ren), .b_wr_en_out(b_we), .b_wdata_out(b_din), .b_addr_out(b_addr));

	// ----------------------------------------
	// Shared tasks
	// ----------------------------------------
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			num_errors++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	function automatic logic [31:0] flags();
		return {28'h0000000, full, afull, aempty, empty};
	endfunction

	task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
		@(posedge sys_clk);
		{reg_wr, reg_addr, reg_wdata} <= {1'b1, a, d};
		@(posedge sys_clk);
		reg_wr <= 1'b0;
	endtask

	// Read data stand only in the cycle after the strobe
	task automatic reg_read(input logic [7:0] a, output logic [31:0] d);
		@(posedge sys_clk);
		{reg_rd, reg_addr} <= {1'b1, a};
		@(posedge sys_clk);
		reg_rd <= 1'b0;
		#1 d = reg_rdata;
	endtask

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic t_regs();
		logic [7:0]  ofs [9] = '{`BRFWM_OFS_CTRL, `BRFWM_OFS_FULL_THR, `BRFWM_OFS_AFULL_THR, `BRFWM_OFS_AEMPT_THR,
		                         `BRFWM_OFS_STATUS, `BRFWM_OFS_INT_EN, `BRFWM_OFS_INT_CLR, `BRFWM_OFS_LEVEL, 8'h20};
		logic [31:0] val [9] = '{32'h00000001, 32'h0000000F, 32'h0000000C, 32'h00000003, 32'h0, 32'h0, 32'h0,
		                         32'h00001000, 32'h0};
		logic [31:0] d;
		check(flags(), 32'h00000003);
		for (int i = 0; i < 9; i++) begin
			reg_read(ofs[i], d);
			check(d, val[i]);
		end
	endtask

	task automatic t_queue();
		logic [31:0] d;
		reg_write(`BRFWM_OFS_INT_EN, 32'h00000010);
		for (int i = 0; i < 16; i++) begin
			u_user.wr_cycle(1'b1, 4'h0, 8'hA0 + 8'(i));
			if (i == 11) check(flags(), 32'h00000007);
			if (i == 14) check(flags(), 32'h0000000F);
		end
		reg_read(`BRFWM_OFS_STATUS, d);
		check(d & 32'h00000033, 32'h00000013);
		check(32'(irq), 32'h00000001);
		reg_write(`BRFWM_OFS_INT_CLR, 32'h00000010);
		repeat (3) @(posedge sys_clk);
		check(32'(irq), 32'h00000000);
		for (int i = 0; i < 15; i++) begin
			u_user.rd_cycle(1'b0, 4'h0, 8'h00);
			check(32'(b_data), 32'hA0 + 32'(i));
			if (i == 0) check(flags(), 32'h0000000C);
		end
		check(flags(), 32'h0000000F);
		u_user.gap = 6;
		for (int i = 0; i < 4; i++) begin
			u_user.wr_cycle(1'b1, 4'h0, 8'hC0 + 8'(i));
			if (i == 0) check(flags(), 32'h00000003);
		end
		for (int i = 0; i < 5; i++) begin
			u_user.rd_cycle(1'b0, 4'h0, 8'h00);
			check(32'(b_data), 32'hC0 + 32'(i < 4 ? i : 3));
		end
		u_user.gap = 0;
		reg_read(`BRFWM_OFS_STATUS, d);
		check(d & 32'h00000020, 32'h00000020);
		check(32'(irq), 32'h00000000);
	endtask

	task automatic t_rewind();
		q_rst <= 1'b1;
		repeat (8) @(posedge sys_clk);
		q_rst <= 1'b0;
		repeat (8) @(posedge sys_clk);
		check(flags(), 32'h00000003);
		reg_write(`BRFWM_OFS_FULL_THR, 32'h00000003);
		for (int i = 0; i < 4; i++) u_user.wr_cycle(1'b1, 4'h0, 8'hB0 + 8'(i));
		check(flags(), 32'h0000000B);
		repeat (2) u_user.rd_cycle(1'b0, 4'h0, 8'h00);
		rewind <= 1'b1;
		repeat (8) @(posedge sys_clk);
		rewind <= 1'b0;
		repeat (8) @(posedge sys_clk);
		for (int i = 0; i < 3; i++) begin
			u_user.rd_cycle(1'b0, 4'h0, 8'h00);
			check(32'(b_data), 32'hB0 + 32'(i));
		end
		u_user.wr_cycle(1'b1, 4'h0, 8'hBE);
		u_user.rd_cycle(1'b0, 4'h0, 8'h00);
		check(32'(b_data), 32'h000000BE);
	endtask

	task automatic t_modes();
		logic [31:0] ea [3] = '{32'h44, 32'h51, 32'h32};
		logic [31:0] eb [3] = '{32'h50, 32'h61, 32'h52};
		reg_write(`BRFWM_OFS_CTRL, 32'h00000000);
		u_user.wr_cycle(1'b1, 4'h4, 8'h44);
		for (int m = 0; m < 3; m++) begin
			reg_write(`BRFWM_OFS_CTRL, 32'((m << 1) | (m << 3)));
			u_user.wr_cycle(1'b1, 4'h3, 8'h30 + 8'(m));
			u_user.wr_cycle(1'b0, 4'h4, 8'h00);
			check(32'(a_data), 32'h00000044);
			u_user.wr_cycle(1'b1, 4'h3, 8'h50 + 8'(m));
			check(32'(a_data), ea[m]);
			u_user.rd_cycle(1'b0, 4'h3, 8'h00);
			check(32'(b_data), 32'h50 + 32'(m));
			u_user.rd_cycle(1'b1, 4'h3, 8'h60 + 8'(m));
			check(32'(b_data), eb[m]);
		end
	endtask

	// Async clears act at once; sync clear waits for the port's own clock
	task automatic t_clears();
		reg_write(`BRFWM_OFS_CTRL, 32'h00000020);
		clr_a <= 1'b1;
		repeat (8) @(posedge sys_clk);
		clr_a <= 1'b0;
		repeat (4) @(posedge sys_clk);
		check(32'(a_data), 32'h00000000);
		check(32'(b_data), 32'h00000052);
		clr_all_n <= 1'b0;
		repeat (8) @(posedge sys_clk);
		clr_all_n <= 1'b1;
		repeat (8) @(posedge sys_clk);
		check(32'(b_data), 32'h00000000);
		reg_write(`BRFWM_OFS_CTRL, 32'h00000000);
		u_user.rd_cycle(1'b0, 4'h3, 8'h00);
		clr_b <= 1'b1;
		repeat (8) @(posedge sys_clk);
		check(32'(b_data), 32'h00000062);
		u_user.rd_cycle(1'b0, 4'h3, 8'h00);
		clr_b <= 1'b0;
		check(32'(b_data), 32'h00000000);
	endtask

	// ----------------------------------------
	// Verdict, main sequence and watchdog
	// ----------------------------------------
	task automatic final_report();
		$display("checks %0d, mismatches %0d", n_checks, num_errors);
		if (num_errors == 0 && n_checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	initial begin
		repeat (20) @(posedge sys_clk);
		rst_n <= 1'b1;
		repeat (10) @(posedge sys_clk);
		t_regs();
		t_queue();
		t_rewind();
		t_modes();
		t_clears();
		final_report();
	end

	// Whole run needs about 13 us; a hang is cut off well after that
	initial begin
		#200000;
		num_errors++;
		final_report();
	end
endmodule

/* dv/brfwm_user_model.sv */
/*
 * User logic model: pushes into and pops from the queue, or drives RAM ports A and B.
 * Assumes sys_clk_in is the block's 100 MHz clock; back-to-back pulses give a 160 ns link period.
 */
module brfwm_user_model (
	input  wire logic       sys_clk_in,
	output logic            write_clock_out,
	output logic            write_clock_enable_out,
	output logic            wr_en_out,
	output logic      [7:0] wr_data_out,
	output logic      [3:0] a_addr_out,
	output logic            read_clock_out,
	output logic            read_clock_enable_out,
	output logic            rd_en_out,
	output logic            b_wr_en_out,
	output logic      [7:0] b_wdata_out,
	output logic      [3:0] b_addr_out
);
	timeunit 1ns;
	timeprecision 100ps;

	int gap = 0; // Extra idle cycles after a pulse, to answer slowly

	// Link clocks stand still between pulses
	initial begin
		{write_clock_out, write_clock_enable_out, wr_en_out} = 3'h0;
		{read_clock_out, read_clock_enable_out, rd_en_out, b_wr_en_out} = 4'h0;
		{wr_data_out, b_wdata_out, a_addr_out, b_addr_out} = 24'h000000;
	end

	// ----------------------------------------
	// One write-clock pulse, pins steady 70 ns before and 80 ns after the rise
	// ----------------------------------------
	task automatic wr_cycle(input logic we, input logic [3:0] addr, input logic [7:0] data);
		@(posedge sys_clk_in);
		write_clock_enable_out <= 1'b1;
		wr_en_out              <= we;
		a_addr_out             <= addr;
		wr_data_out            <= data;
		repeat (7) @(posedge sys_clk_in);
		write_clock_out <= 1'b1;
		repeat (8) @(posedge sys_clk_in);
		write_clock_out        <= 1'b0;
		write_clock_enable_out <= 1'b0;
		wr_en_out              <= 1'b0;
		wr_data_out            <= ~data; // Released data never shows the old value
		repeat (gap) @(posedge sys_clk_in);
	endtask

	// ----------------------------------------
	// One read-clock pulse, same shape on the independent side
	// ----------------------------------------
	task automatic rd_cycle(input logic we, input logic [3:0] addr, input logic [7:0] data);
		@(posedge sys_clk_in);
		read_clock_enable_out <= 1'b1;
		rd_en_out             <= 1'b1;
		b_wr_en_out           <= we;
		b_addr_out            <= addr;
		b_wdata_out           <= data;
		repeat (7) @(posedge sys_clk_in);
		read_clock_out <= 1'b1;
		repeat (8) @(posedge sys_clk_in);
		read_clock_out        <= 1'b0;
		read_clock_enable_out <= 1'b0;
		rd_en_out             <= 1'b0;
		b_wr_en_out           <= 1'b0;
		b_wdata_out           <= ~data;
		repeat (gap) @(posedge sys_clk_in);
	endtask
endmodule

/* include/brfwm_pkg.sv */
/*
 * Types shared by the block RAM queue.
 * Assumes nothing of its surroundings.
 */
package brfwm_pkg;
	// ----------------------------------------
	// Per-port write behaviour
	// ----------------------------------------
	typedef enum logic [1:0] {
		BRFWM_NORMAL,
		BRFWM_THROUGH,
		BRFWM_RD_BEFORE_WR
	} brfwm_wmode_t;
endpackage

/* include/brfwm_regs.svh */
/*
 * Register offsets, field positions and reset values of the block RAM queue.
 * Assumes byte addresses on an 8-bit register address and 32-bit data.
 */
`ifndef BRFWM_REGS_SVH
`define BRFWM_REGS_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define BRFWM_OFS_CTRL      8'h00
`define BRFWM_OFS_FULL_THR  8'h04
`define BRFWM_OFS_AFULL_THR 8'h08
`define BRFWM_OFS_AEMPT_THR 8'h0C
`define BRFWM_OFS_STATUS    8'h10
`define BRFWM_OFS_INT_EN    8'h14
`define BRFWM_OFS_INT_CLR   8'h18
`define BRFWM_OFS_LEVEL     8'h1C

// ----------------------------------------
// Control fields
// ----------------------------------------
`define BRFWM_CTRL_QUEUE    0
`define BRFWM_CTRL_AMODE_LO 1
`define BRFWM_CTRL_BMODE_LO 3
`define BRFWM_CTRL_ASYNC    5
`define BRFWM_CTRL_W        6
`define BRFWM_CTRL_RST      6'h01

// ----------------------------------------
// Status and interrupt bits
// ----------------------------------------
`define BRFWM_ST_FULL       0
`define BRFWM_ST_AFULL      1
`define BRFWM_ST_AEMPT      2
`define BRFWM_ST_EMPTY      3
`define BRFWM_ST_OVER       4
`define BRFWM_ST_UNDER      5
`define BRFWM_ST_W          6

// ----------------------------------------
// Threshold reset values
// ----------------------------------------
`define BRFWM_FULL_RST      32'h0000000F
`define BRFWM_AFULL_RST     32'h0000000C
`define BRFWM_AEMPT_RST     32'h00000003

`endif

/* verilog/brfwm_top.sv */
/*
 * Block RAM with per-port write behaviour, usable as a plain two-port RAM or as a queue.
 * Assumes write and read clocks and all user pins are asynchronous to sys_clk_in and
 * at least four times slower than it; registers sit on a plain strobe port.
 */
// Decided for this implementation: strobed register access and the register addresses.
// What this block does
// RULE1 - Normal mode: write never shows on output
// RULE2 - Write-through mode: output copies written data
// RULE3 - Read-before-write: output shows old contents
// RULE4 - Writes qualified by enables on write clock
// RULE5 - Independent read side on read clock
// RULE6 - Generate full, almost-full, almost-empty, empty
// RULE7 - Full threshold programmable one to 2^N-1
// RULE8 - Full flags registered on write clock
// RULE9 - Empty flags registered on read clock
// RULE10 - Queue reset clears pointers and flags
// RULE11 - Rewind resets only the read pointer
// RULE12 - Output clears selectable synchronous or asynchronous
// RULE13 - Per-port clear affects only its port
// RULE14 - Active-low device clear clears both ports
// RULE15 - Pointers N bits, wrapping circularly
`include "brfwm_regs.svh"
module brfwm_top #(
	parameter int W  = 8,                       // Data width
	parameter int AW = 4                        // Address width N
) (
	input  wire logic          sys_clk_in,
	input  wire logic          rst_n_in,
	input  wire logic [7:0]    reg_addr_in,
	input  wire logic [31:0]   reg_wdata_in,
	input  wire logic          reg_wr_in,
	input  wire logic          reg_rd_in,
	output logic      [31:0]   reg_rdata_out,
	output logic               irq_out,
	input  wire logic          write_clock_in,
	input  wire logic          write_clock_enable_in,
	input  wire logic          wr_en_in,
	input  wire logic [W-1:0]  wr_data_in,
	input  wire logic [AW-1:0] a_addr_in,
	output logic      [W-1:0]  a_data_out,
	input  wire logic          read_clock_in,
	input  wire logic          read_clock_enable_in,
	input  wire logic          rd_en_in,
	input  wire logic          b_wr_en_in,
	input  wire logic [W-1:0]  b_data_in,
	input  wire logic [AW-1:0] b_addr_in,
	output logic      [W-1:0]  b_data_out,
	input  wire logic          queue_reset_in,
	input  wire logic          read_pointer_rewind_in,
	input  wire logic          port_a_output_clear_in,
	input  wire logic          port_b_output_clear_in,
	input  wire logic          device_wide_clear_n_in,
	output logic               full_flag_out,
	output logic               almost_full_flag_out,
	output logic               almost_empty_flag_out,
	output logic               empty_flag_out
);
	// ----------------------------------------
	// Local sizes and pin vector layout
	// ----------------------------------------
	localparam int DEPTH = 1 << AW;
	localparam int IW    = 12 + 2 * W + 2 * AW;     // Width of the synchronised pin bundle
	localparam int P_WCK = IW - 1;
	localparam int P_RCK = IW - 2;

	logic [1:0]     rst_sync_q;                    // Reset release chain
	logic           rst_n;                         // Released reset copy
	logic [IW-1:0]  pin_raw;                       // Pins gathered into one vector
	logic [IW-1:0]  s1_q, s2_q, s3_q;              // Three-stage synchroniser
	logic [IW-1:0]  flt_q, flt_d;                  // Value accepted once stages two and three agree
	logic           wck, rck, wce, wen, read_clock_enable, ren, bwe, qrst, rewind, clra, clrb, gclr_n;
	logic [W-1:0]   wdata, bdata;
	logic [AW-1:0]  aaddr, baddr;
	logic           wr_evt, rd_evt, push, pop, over, under;
	logic [W-1:0]   mem_q [DEPTH];                 // Storage, flip-flops
	logic [W-1:0]   mem_d [DEPTH];
	logic [AW-1:0]  wptr_q, wptr_d, rptr_q, rptr_d;
	logic [AW:0]    cnt_q, cnt_d;                  // Fill level, one bit wider than pointers
	logic [W-1:0]   adout_q, adout_d, bdout_q, bdout_d;
	logic           full_q, full_d, afull_q, afull_d, aempt_q, aempt_d, empty_q, empty_d;
	logic [`BRFWM_CTRL_W-1:0] ctrl_q, ctrl_d;     // Mode and clear style
	logic [AW-1:0]  fthr_q, fthr_d, afthr_q, afthr_d, aethr_q, aethr_d;
	logic [`BRFWM_ST_W-1:0] sts_q, sts_d, ien_q, ien_d, evt;
	logic [31:0]    rdata_q, rdata_d;
	logic           irq_q, irq_d;
	logic           qmode, async_clr;
	logic [1:0]     amode, bmode;

	// ----------------------------------------
	// Output selection by write behaviour
	// ----------------------------------------
	// Picks what a writing port shows: held value, new data or old contents
	function automatic logic [W-1:0] port_out(input logic [1:0] mode, input logic [W-1:0] old_v,
			input logic [W-1:0] new_v, input logic [W-1:0] cur_v);
		unique case (brfwm_pkg::brfwm_wmode_t'(mode))
			brfwm_pkg::BRFWM_NORMAL:       port_out = cur_v;   // [RULE1]
			brfwm_pkg::BRFWM_THROUGH:      port_out = new_v;   // [RULE2]
			brfwm_pkg::BRFWM_RD_BEFORE_WR: port_out = old_v;   // [RULE3]
			default:                       port_out = cur_v;   // Unused code behaves as normal
		endcase
	endfunction

	// ----------------------------------------
	// Reset release
	// ----------------------------------------
	// Two flops so release never lands near an edge
	always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			rst_sync_q <= 2'h0;
		end else begin
			rst_sync_q <= {rst_sync_q[0], 1'b1};
		end
	end
	assign rst_n = rst_sync_q[1];

	// ----------------------------------------
	// Pin synchronisation
	// ----------------------------------------
	assign pin_raw = {write_clock_in, read_clock_in, write_clock_enable_in, wr_en_in, read_clock_enable_in,
		rd_en_in, b_wr_en_in, queue_reset_in, read_pointer_rewind_in, port_a_output_clear_in,
		port_b_output_clear_in, device_wide_clear_n_in, wr_data_in, a_addr_in, b_data_in, b_addr_in};

	// A bit moves only when stages two and three agree, filtering one-sample glitches
	always_comb begin
		flt_d = (s3_q & ~(s2_q ^ s3_q)) | (flt_q & (s2_q ^ s3_q));
	end

	// Pin registers; all bits start low, so device clear reads active until pins settle
	always_ff @(posedge sys_clk_in or negedge rst_n) begin
		if (!rst_n) begin
			s1_q  <= '0;
			s2_q  <= '0;
			s3_q  <= '0;
			flt_q <= '0;
		end else begin
			s1_q  <= pin_raw;
			s2_q  <= s1_q;
			s3_q  <= s2_q;
			flt_q <= flt_d;
		end
	end

	assign {wck, rck, wce, wen, read_clock_enable, ren, bwe, qrst, rewind, clra, clrb, gclr_n, wdata, aaddr, bdata, baddr} = flt_q;
	assign qmode     = ctrl_q[`BRFWM_CTRL_QUEUE];
	assign amode     = ctrl_q[`BRFWM_CTRL_AMODE_LO +: 2];
	assign bmode     = ctrl_q[`BRFWM_CTRL_BMODE_LO +: 2];
	assign async_clr = ctrl_q[`BRFWM_CTRL_ASYNC];

	// ----------------------------------------
	// Datapath next state
	// ----------------------------------------
	always_comb begin
		mem_d   = mem_q;
		wptr_d  = wptr_q;
		rptr_d  = rptr_q;
		cnt_d   = cnt_q;
		adout_d = adout_q;
		bdout_d = bdout_q;
		full_d  = full_q;
		afull_d = afull_q;
		aempt_d = aempt_q;
		empty_d = empty_q;
		// Rising edges of the recovered port clocks, gated by their clock enables
		wr_evt = flt_d[P_WCK] & ~flt_q[P_WCK] & wce;     // [RULE4]
		rd_evt = flt_d[P_RCK] & ~flt_q[P_RCK] & read_clock_enable;     // [RULE5]
		push   = qmode & wr_evt & wen & (cnt_q < {1'b0, fthr_q});   // [RULE7]
		pop    = qmode & rd_evt & ren & (cnt_q != '0);
		over   = qmode & wr_evt & wen & ~push;
		under  = qmode & rd_evt & ren & ~pop;
		if (qmode) begin
			// Queue: port A writes at the write pointer, port B reads at the read pointer
			if (push) begin
				mem_d[wptr_q] = wdata;
				adout_d       = port_out(amode, mem_q[wptr_q], wdata, adout_q);
				wptr_d        = wptr_q + 1'b1;                 // [RULE15]
			end
			if (pop) begin
				bdout_d = mem_q[rptr_q];
				rptr_d  = rptr_q + 1'b1;                       // [RULE15]
			end
			cnt_d = cnt_q + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
			// Rewind: data written since slot zero becomes readable again
			if (rewind) begin
				rptr_d = '0;                                   // [RULE11]
				cnt_d  = {1'b0, wptr_d};
			end
		end else begin
			// Plain RAM: each port reads or writes at its own address
			if (wr_evt) begin
				if (wen) begin
					mem_d[aaddr] = wdata;
					adout_d      = port_out(amode, mem_q[aaddr], wdata, adout_q);
				end else begin
					adout_d = mem_q[aaddr];
				end
			end
			// Port B is written last, so it wins a same-address collision
			if (rd_evt) begin
				if (bwe) begin
					mem_d[baddr] = bdata;
					bdout_d      = port_out(bmode, mem_q[baddr], bdata, bdout_q);
				end else begin
					bdout_d = mem_q[baddr];
				end
			end
		end
		// Full side flags sample the level on the write clock only
		if (wr_evt) begin
			full_d  = cnt_d >= {1'b0, fthr_q};                 // [RULE6] [RULE8]
			afull_d = cnt_d >= {1'b0, afthr_q};
		end
		// Empty side flags sample the level on the read clock only
		if (rd_evt) begin
			empty_d = cnt_d == '0;                             // [RULE6] [RULE9]
			aempt_d = cnt_d <= {1'b0, aethr_q};
		end
		// Queue reset overrides everything on the pointers and flags
		if (qrst) begin
			wptr_d  = '0;                                      // [RULE10]
			rptr_d  = '0;
			cnt_d   = '0;
			full_d  = 1'b0;
			afull_d = 1'b0;
			aempt_d = 1'b1;
			empty_d = 1'b1;
		end
		// Clears: asynchronous style acts at once, synchronous waits for its port clock
		if ((clra | ~gclr_n) & (async_clr | wr_evt)) begin
			adout_d = '0;                                      // [RULE12] [RULE13] [RULE14]
		end
		if ((clrb | ~gclr_n) & (async_clr | rd_evt)) begin
			bdout_d = '0;                                      // [RULE12] [RULE13] [RULE14]
		end
	end

	// Datapath registers
	always_ff @(posedge sys_clk_in or negedge rst_n) begin
		if (!rst_n) begin
			for (int i = 0; i < DEPTH; i++) begin
				mem_q[i] <= '0;
			end
			wptr_q  <= '0;
			rptr_q  <= '0;
			cnt_q   <= '0;
			adout_q <= '0;
			bdout_q <= '0;
			full_q  <= 1'b0;
			afull_q <= 1'b0;
			aempt_q <= 1'b1;
			empty_q <= 1'b1;
		end else begin
			mem_q   <= mem_d;
			wptr_q  <= wptr_d;
			rptr_q  <= rptr_d;
			cnt_q   <= cnt_d;
			adout_q <= adout_d;
			bdout_q <= bdout_d;
			full_q  <= full_d;
			afull_q <= afull_d;
			aempt_q <= aempt_d;
			empty_q <= empty_d;
		end
	end

	// ----------------------------------------
	// Register port and interrupt next state
	// ----------------------------------------
	always_comb begin
		ctrl_d  = ctrl_q;
		fthr_d  = fthr_q;
		afthr_d = afthr_q;
		aethr_d = aethr_q;
		ien_d   = ien_q;
		rdata_d = '0;
		// Sticky events: flag rises plus refused pushes and pops
		evt = '0;
		evt[`BRFWM_ST_FULL]  = full_d & ~full_q;
		evt[`BRFWM_ST_AFULL] = afull_d & ~afull_q;
		evt[`BRFWM_ST_AEMPT] = aempt_d & ~aempt_q;
		evt[`BRFWM_ST_EMPTY] = empty_d & ~empty_q;
		evt[`BRFWM_ST_OVER]  = over;
		evt[`BRFWM_ST_UNDER] = under;
		sts_d = sts_q;
		if (reg_wr_in) begin
			unique case (reg_addr_in)
				`BRFWM_OFS_CTRL:      ctrl_d  = reg_wdata_in[`BRFWM_CTRL_W-1:0];
				`BRFWM_OFS_FULL_THR:  fthr_d  = reg_wdata_in[AW-1:0];       // [RULE7]
				`BRFWM_OFS_AFULL_THR: afthr_d = reg_wdata_in[AW-1:0];
				`BRFWM_OFS_AEMPT_THR: aethr_d = reg_wdata_in[AW-1:0];
				`BRFWM_OFS_INT_EN:    ien_d   = reg_wdata_in[`BRFWM_ST_W-1:0];
				`BRFWM_OFS_INT_CLR:   sts_d   = sts_q & ~reg_wdata_in[`BRFWM_ST_W-1:0];
				default:              ;                                     // Unmapped writes dropped
			endcase
		end
		// Set after clear, so an event in the clearing cycle survives
		sts_d = sts_d | evt;
		if (reg_rd_in) begin
			unique case (reg_addr_in)
				`BRFWM_OFS_CTRL:      rdata_d[`BRFWM_CTRL_W-1:0] = ctrl_q;
				`BRFWM_OFS_FULL_THR:  rdata_d[AW-1:0] = fthr_q;
				`BRFWM_OFS_AFULL_THR: rdata_d[AW-1:0] = afthr_q;
				`BRFWM_OFS_AEMPT_THR: rdata_d[AW-1:0] = aethr_q;
				`BRFWM_OFS_STATUS:    rdata_d[`BRFWM_ST_W-1:0] = sts_q;
				`BRFWM_OFS_INT_EN:    rdata_d[`BRFWM_ST_W-1:0] = ien_q;
				`BRFWM_OFS_LEVEL:     rdata_d = {12'h000, 4'(full_q), 4'(empty_q), 12'(cnt_q)};
				default:              rdata_d = '0;                         // Unmapped and clear read zero
			endcase
		end
		irq_d = |(sts_d & ien_d);
	end

	// Register port registers
	always_ff @(posedge sys_clk_in or negedge rst_n) begin
		if (!rst_n) begin
			ctrl_q  <= `BRFWM_CTRL_RST;
			fthr_q  <= AW'(`BRFWM_FULL_RST);
			afthr_q <= AW'(`BRFWM_AFULL_RST);
			aethr_q <= AW'(`BRFWM_AEMPT_RST);
			ien_q   <= '0;
			sts_q   <= '0;
			rdata_q <= '0;
			irq_q   <= 1'b0;
		end else begin
			ctrl_q  <= ctrl_d;
			fthr_q  <= fthr_d;
			afthr_q <= afthr_d;
			aethr_q <= aethr_d;
			ien_q   <= ien_d;
			sts_q   <= sts_d;
			rdata_q <= rdata_d;
			irq_q   <= irq_d;
		end
	end

	assign reg_rdata_out         = rdata_q;
	assign irq_out               = irq_q;
	assign a_data_out            = adout_q;
	assign b_data_out            = bdout_q;
	assign full_flag_out         = full_q;
	assign almost_full_flag_out  = afull_q;
	assign almost_empty_flag_out = aempt_q;
	assign empty_flag_out        = empty_q;

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	default clocking cb @(posedge sys_clk_in); endclocking
	default disable iff (!rst_n);

	logic aclr_now;                                    // Port A clear acting this cycle
	assign aclr_now = (clra | ~gclr_n) & (async_clr | wr_evt);

	sequence s_a_write(logic [1:0] m);
		wr_evt && wen && (push || !qmode) && amode == m && !aclr_now;
	endsequence
	sequence s_rewind_only;
		rewind && qmode && !qrst && !push;
	endsequence

	AST_NORMAL: assert property (s_a_write(2'h0) |=> $stable(a_data_out)) // [RULE1]
		else $error("normal write changed port A output");
	AST_THROUGH: assert property (s_a_write(2'h1) |=> a_data_out == $past(wdata)) // [RULE2]
		else $error("write-through output differs from written data");
	AST_RBW: assert property (!qmode ##0 s_a_write(2'h2) |=> a_data_out == $past(mem_q[aaddr])) // [RULE3]
		else $error("read-before-write did not show old contents");
	AST_WR_SIDE: assert property (!qrst && !$past(qrst) && $changed(wptr_q) |-> $past(push)) // [RULE4]
		else $error("write pointer moved without a qualified write");
	AST_RD_SIDE: assert property (!qrst && !rewind ##1 $changed(rptr_q) |-> $past(pop)) // [RULE5]
		else $error("read pointer moved without a qualified read");
	AST_FULL_REG: assert property ($changed(full_flag_out) |-> $past(wr_evt) || $past(qrst)) // [RULE8]
		else $error("full flag changed off the write clock");
	AST_EMPTY_REG: assert property ($changed(empty_flag_out) |-> $past(rd_evt) || $past(qrst)) // [RULE9]
		else $error("empty flag changed off the read clock");
	AST_EMPTY_LVL: assert property (rd_evt && !qrst |=> empty_flag_out == (cnt_q == '0)) // [RULE6]
		else $error("empty flag disagrees with level");
	AST_NO_OVER: assert property (push |-> cnt_q < {1'b0, fthr_q} ##1 cnt_q <= {1'b0, $past(fthr_q)}) // [RULE7]
		else $error("push accepted at or above full threshold");
	AST_GRST: assert property (qrst |=> wptr_q == '0 && rptr_q == '0 && empty_flag_out && !full_flag_out) // [RULE10]
		else $error("queue reset left pointers or flags");
	AST_REWIND: assert property (s_rewind_only |=> rptr_q == '0 && $stable(wptr_q)) // [RULE11]
		else $error("rewind disturbed more than the read pointer");
	AST_CLR_A: assert property (clra && gclr_n && async_clr && !clrb && !rd_evt // [RULE13]
		|=> a_data_out == '0 && $stable(b_data_out))
		else $error("port A clear wrong");
	AST_GCLR: assert property (!gclr_n && async_clr |=> a_data_out == '0 && b_data_out == '0) // [RULE14] [RULE12]
		else $error("device clear missed a port");
	AST_WRAP: assert property (push && !qrst && wptr_q == AW'(DEPTH - 1) |=> wptr_q == '0) // [RULE15]
		else $error("write pointer did not wrap");
endmodule
